// >>> cpgc_consts.svh
// offsets, field positions, reset values and limits for coarse path gain control
`ifndef CPGC_CONSTS_SVH
`define CPGC_CONSTS_SVH

//------------------------------------------------------------
// register offsets
//------------------------------------------------------------
`define CPGC_TX_OFF      8'h26
`define CPGC_RX_OFF      8'h27

//------------------------------------------------------------
// field positions
//------------------------------------------------------------
`define CPGC_DIR_BIT     4
`define CPGC_MAG_MSB     3
`define CPGC_MAG_LSB     0
`define CPGC_USED_MSB    4

//------------------------------------------------------------
// reset values and gain limits (in dB)
//------------------------------------------------------------
`define CPGC_CTRL_RST    5'h00
`define CPGC_GAIN_MAX    5'h0C
`define CPGC_SAT_PREFIX  2'h3

`endif

// >>> cpgc_pkg.sv
// types shared by the coarse path gain control block
`default_nettype none

package cpgc_pkg;

	// one coarse gain control register, used bits only
	typedef struct packed {
		logic       dir;    // 0 raises gain, 1 attenuates
		logic [3:0] mag;    // magnitude code, 1 dB per step
	} cpgc_ctrl_type;

	// decoded gain of one path, signed whole dB
	typedef logic signed [4:0] cpgc_db_type;

	// path index
	typedef enum logic {
		CPGC_PATH_TX,
		CPGC_PATH_RX
	} cpgc_path_type;

endpackage

`default_nettype wire

// >>> cpgc_decode.sv
// decoder from a coarse gain control register to a signed dB setting
`default_nettype none
`include "cpgc_consts.svh"

module cpgc_decode
	import cpgc_pkg::*;
(
	input  wire cpgc_ctrl_type ctrl_i,   // direction and magnitude
	output var cpgc_db_type    db_o      // signed gain, negative is attenuation
);

	//------------------------------------------------------------
	// gain decode
	//------------------------------------------------------------
	// combinational mapping of code to dB
	always_comb begin
		db_o = 5'h00;
		// [RQ7] zero code is unity
		if (ctrl_i.mag == 4'h0) begin
			db_o = 5'h00;
		end else if (!ctrl_i.dir) begin
			// [RQ1] [RQ2] clear direction gains up
			// [RQ4] [RQ5] gain saturates high
			if (ctrl_i.mag[3:2] == `CPGC_SAT_PREFIX) begin
				db_o = `CPGC_GAIN_MAX;
			end else begin
				// [RQ3] one dB per step
				db_o = $signed({1'b0, ctrl_i.mag});
			end
		end else begin
			// [RQ6] attenuation one dB per step
			db_o = -$signed({1'b0, ctrl_i.mag});
		end
	end

endmodule

`default_nettype wire

// >>> cpgc_top.sv
// coarse transmit and receive path gain control registers with decoded gain outputs
//
// Behaviour
// [RQ1] tx bit 4 picks gain or attenuation
// [RQ2] rx bit 4 picks gain or attenuation
// [RQ3] each magnitude step is one dB
// [RQ4] tx gain codes 11xx give 12 dB
// [RQ5] rx gain codes 11xx give 12 dB
// [RQ6] attenuation 0001 is 1 dB, 1111 15 dB
// [RQ7] magnitude zero is unity either direction
// [RQ8] bits 7..5 ignored on write, read zero
`default_nettype none
`include "cpgc_consts.svh"

module cpgc_top
	import cpgc_pkg::*;
#(
	parameter int DATA_W = 8,   // register data width
	parameter int ADDR_W = 8    // register address width
)(
	input  wire logic              core_clk_i,     // system clock, 10 MHz
	input  wire logic              rstn_i,         // asynchronous reset, active low
	input  wire logic [ADDR_W-1:0] reg_addr_i,     // register address from control port
	input  wire logic [DATA_W-1:0] reg_wdata_i,    // register write data
	input  wire logic              reg_wr_i,       // write strobe, one cycle
	input  wire logic              reg_rd_i,       // read strobe, one cycle
	output logic      [DATA_W-1:0] reg_rdata_o,    // registered read data
	output logic                   reg_rvalid_o,   // read data valid, one cycle
	output var cpgc_db_type        tx_gain_db_o,   // transmit path gain in dB
	output var cpgc_db_type        rx_gain_db_o    // receive path gain in dB
);

	//------------------------------------------------------------
	// declarations
	//------------------------------------------------------------
	localparam int NPATH = 2;                         // transmit and receive

	cpgc_ctrl_type     ctrl_r   [NPATH];              // control registers
	cpgc_ctrl_type     ctrl_nxt [NPATH];              // their next values
	cpgc_db_type       db_dec   [NPATH];              // decoded gain per path
	cpgc_db_type       db_r     [NPATH];              // registered gain per path
	cpgc_db_type       db_nxt   [NPATH];              // next registered gain
	logic [NPATH-1:0]  hit;                           // address matches a path
	logic [DATA_W-1:0] rdata_r;                       // read data register
	logic [DATA_W-1:0] rdata_nxt;                     // next read data
	logic              rvalid_r;                      // read valid register
	logic              rvalid_nxt;                    // next read valid

	//------------------------------------------------------------
	// address decode
	//------------------------------------------------------------
	// one hit line per path, if-else chain
	always_comb begin
		hit = '0;
		if (reg_addr_i == `CPGC_TX_OFF) begin
			hit[CPGC_PATH_TX] = 1'b1;
		end else if (reg_addr_i == `CPGC_RX_OFF) begin
			hit[CPGC_PATH_RX] = 1'b1;
		end else begin
			// unmapped address: writes dropped, reads return zero
			hit = '0;
		end
	end

	//------------------------------------------------------------
	// per path control register and decoder
	//------------------------------------------------------------
	for (genvar p = 0; p < NPATH; p++) begin : g_path
		// next value of the control register
		always_comb begin
			ctrl_nxt[p] = ctrl_r[p];
			if (reg_wr_i && hit[p]) begin
				// [RQ8] upper bits dropped on write
				ctrl_nxt[p] = reg_wdata_i[`CPGC_USED_MSB:0];
			end
		end

		// decoder for this path
		cpgc_decode u_decode (
			.ctrl_i (ctrl_r[p]),
			.db_o   (db_dec[p])
		);

		// gain output follows decoder one cycle later
		always_comb begin
			db_nxt[p] = db_dec[p];
		end

		// register the control word and the gain
		always_ff @(posedge core_clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				ctrl_r[p] <= `CPGC_CTRL_RST;
				db_r[p]   <= 5'h00;
			end else begin
				ctrl_r[p] <= ctrl_nxt[p];
				db_r[p]   <= db_nxt[p];
			end
		end
	end

	//------------------------------------------------------------
	// read path
	//------------------------------------------------------------
	// read data and valid next values
	always_comb begin
		rdata_nxt  = '0;
		rvalid_nxt = reg_rd_i;
		if (reg_rd_i) begin
			if (hit[CPGC_PATH_TX]) begin
				// [RQ8] upper bits read zero
				rdata_nxt = {3'h0, ctrl_r[CPGC_PATH_TX]};
			end else if (hit[CPGC_PATH_RX]) begin
				rdata_nxt = {3'h0, ctrl_r[CPGC_PATH_RX]};
			end else begin
				// unmapped reads as zero
				rdata_nxt = '0;
			end
		end
	end

	// read registers
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_r  <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	//------------------------------------------------------------
	// outputs
	//------------------------------------------------------------
	assign reg_rdata_o  = rdata_r;
	assign reg_rvalid_o = rvalid_r;
	assign tx_gain_db_o = db_r[CPGC_PATH_TX];
	assign rx_gain_db_o = db_r[CPGC_PATH_RX];

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	tx_direction_a: assert property ( // [RQ1]
		@(posedge core_clk_i) disable iff (!rstn_i)
		(ctrl_r[CPGC_PATH_TX].mag != 4'h0) |=>
			((tx_gain_db_o < 0) == $past(ctrl_r[CPGC_PATH_TX].dir)))
		else $error("tx gain sign does not follow direction bit");

	rx_direction_a: assert property ( // [RQ2]
		@(posedge core_clk_i) disable iff (!rstn_i)
		(ctrl_r[CPGC_PATH_RX].mag != 4'h0) |=>
			((rx_gain_db_o < 0) == $past(ctrl_r[CPGC_PATH_RX].dir)))
		else $error("rx gain sign does not follow direction bit");

	tx_step_size_a: assert property ( // [RQ3]
		@(posedge core_clk_i) disable iff (!rstn_i)
		(!ctrl_r[CPGC_PATH_TX].dir && ctrl_r[CPGC_PATH_TX].mag[3:2] != 2'h3) |=>
			(tx_gain_db_o == $signed({1'b0, $past(ctrl_r[CPGC_PATH_TX].mag)})))
		else $error("tx gain step is not one dB per code");

	tx_gain_sat_a: assert property ( // [RQ4]
		@(posedge core_clk_i) disable iff (!rstn_i)
		(!ctrl_r[CPGC_PATH_TX].dir && ctrl_r[CPGC_PATH_TX].mag[3:2] == 2'h3) |=>
			(tx_gain_db_o == 5'sd12))
		else $error("tx gain did not saturate at 12 dB");

	rx_gain_sat_a: assert property ( // [RQ5]
		@(posedge core_clk_i) disable iff (!rstn_i)
		(!ctrl_r[CPGC_PATH_RX].dir && ctrl_r[CPGC_PATH_RX].mag[3:2] == 2'h3) |=>
			(rx_gain_db_o == 5'sd12))
		else $error("rx gain did not saturate at 12 dB");

	rx_atten_step_a: assert property ( // [RQ6]
		@(posedge core_clk_i) disable iff (!rstn_i)
		(ctrl_r[CPGC_PATH_RX].dir && ctrl_r[CPGC_PATH_RX].mag != 4'h0) |=>
			(rx_gain_db_o == -$signed({1'b0, $past(ctrl_r[CPGC_PATH_RX].mag)})))
		else $error("rx attenuation not one dB per code");

	unity_zero_a: assert property ( // [RQ7]
		@(posedge core_clk_i) disable iff (!rstn_i)
		(ctrl_r[CPGC_PATH_TX].mag == 4'h0 && ctrl_r[CPGC_PATH_RX].mag == 4'h0) |=>
			(tx_gain_db_o == 5'sd0 && rx_gain_db_o == 5'sd0))
		else $error("zero magnitude did not give unity");

	upper_read_zero_a: assert property ( // [RQ8]
		@(posedge core_clk_i) disable iff (!rstn_i)
		reg_rvalid_o |-> (reg_rdata_o[7:5] == 3'h0))
		else $error("reserved bits read back nonzero");

	write_readback_a: assert property ( // [RQ8]
		@(posedge core_clk_i) disable iff (!rstn_i)
		(reg_wr_i && reg_addr_i == `CPGC_TX_OFF) ##1 (reg_rd_i && reg_addr_i == `CPGC_TX_OFF && !reg_wr_i) |=>
			(reg_rdata_o == {3'h0, $past(reg_wdata_i[4:0], 2)}))
		else $error("tx register read back differs from write");

	rx_step_size_a: assert property ( // [RQ3]
		@(posedge core_clk_i) disable iff (!rstn_i)
		(!ctrl_r[CPGC_PATH_RX].dir && ctrl_r[CPGC_PATH_RX].mag[3:2] != 2'h3) |=>
			(rx_gain_db_o == $signed({1'b0, $past(ctrl_r[CPGC_PATH_RX].mag)})))
		else $error("rx gain step is not one dB per code");

	tx_atten_step_a: assert property ( // [RQ6]
		@(posedge core_clk_i) disable iff (!rstn_i)
		(ctrl_r[CPGC_PATH_TX].dir && ctrl_r[CPGC_PATH_TX].mag != 4'h0) |=>
			(tx_gain_db_o == -$signed({1'b0, $past(ctrl_r[CPGC_PATH_TX].mag)})))
		else $error("tx attenuation not one dB per code");

	tx_unity_a: assert property ( // [RQ7]
		@(posedge core_clk_i) disable iff (!rstn_i)
		(ctrl_r[CPGC_PATH_TX].mag == 4'h0) |=>
			(tx_gain_db_o == 5'sd0))
		else $error("tx zero magnitude did not give unity");

	rx_unity_a: assert property ( // [RQ7]
		@(posedge core_clk_i) disable iff (!rstn_i)
		(ctrl_r[CPGC_PATH_RX].mag == 4'h0) |=>
			(rx_gain_db_o == 5'sd0))
		else $error("rx zero magnitude did not give unity");

	tx_write_land_a: assert property ( // [RQ8]
		@(posedge core_clk_i) disable iff (!rstn_i)
		(reg_wr_i && reg_addr_i == `CPGC_TX_OFF) |=>
			(ctrl_r[CPGC_PATH_TX] == $past(reg_wdata_i[4:0])))
		else $error("tx write did not store the used bits");

endmodule

`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the coarse path gain control registers
`default_nettype none
`include "cpgc_consts.svh"

module tb_top
	import cpgc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	//------------------------------------------------------------
	// stimulus and observed signals
	//------------------------------------------------------------
	logic              core_clk;     // 10 MHz system clock
	logic              rst_n;        // reset, active low
	logic [7:0]        reg_addr;     // register address
	logic [7:0]        reg_wdata;    // write data
	logic              reg_wr;       // write strobe
	logic              reg_rd;       // read strobe
	logic [7:0]        reg_rdata;    // read data from block
	logic              reg_rvalid;   // read answer valid
	cpgc_db_type       tx_db;        // transmit gain seen
	cpgc_db_type       rx_db;        // receive gain seen
	logic [4:0]        exp_tx;       // expected transmit gain
	logic [4:0]        exp_rx;       // expected receive gain
	int                n_fail;       // mismatches
	int                tests_run;    // comparisons made

	cpgc_top #(.DATA_W(8), .ADDR_W(8)) DUT (
		.core_clk_i   (core_clk),
		.rstn_i       (rst_n),
		.reg_addr_i   (reg_addr),
		.reg_wdata_i  (reg_wdata),
		.reg_wr_i     (reg_wr),
		.reg_rd_i     (reg_rd),
		.reg_rdata_o  (reg_rdata),
		.reg_rvalid_o (reg_rvalid),
		.tx_gain_db_o (tx_db),
		.rx_gain_db_o (rx_db)
	);

	// free-running clock, 100 ns period
	always #50 core_clk = ~core_clk;

	//------------------------------------------------------------
	// shared helpers
	//------------------------------------------------------------
	// compare and count
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// closing report
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// decoded gain from direction and magnitude
	function automatic logic [4:0] exp_db(input logic dir, input logic [3:0] mag);
		if (mag == 4'h0) return 5'h00;
		if (dir) return 5'h00 - {1'b0, mag};
		return (mag >= 4'hC) ? 5'h0C : {1'b0, mag};
	endfunction

	// write strobe raised at an edge, taken at the next; strobe left up
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
	endtask

	// drop strobes, then wait until gain outputs have landed
	task automatic idle_look;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
	endtask

	// read with bounded wait for the answer, returns at an edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		int i;
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		// answer stands for the cycle after the taking edge
		for (i = 0; i < 4; i++) begin
			#1;
			if (reg_rvalid === 1'b1) break;
			@(posedge core_clk);
		end
		if (i == 4) begin
			n_fail++;
			give_verdict();
		end
		d = reg_rdata;
		@(posedge core_clk);
	endtask

	// both gain outputs against expectation
	task automatic chk_gains;
		chk("tx gain", {3'h0, tx_db}, {3'h0, exp_tx});
		chk("rx gain", {3'h0, rx_db}, {3'h0, exp_rx});
	endtask

	//------------------------------------------------------------
	// scenarios
	//------------------------------------------------------------
	// registers and gains come up at zero
	task automatic t_reset;
		logic [7:0] d;
		#1;
		chk_gains();
		rd(`CPGC_TX_OFF, d);
		chk("tx reset", d, 8'h00);
		rd(`CPGC_RX_OFF, d);
		chk("rx reset", d, 8'h00);
	endtask

	// every direction and code on both paths, upper bits written high
	task automatic t_sweep;
		logic [7:0] d;
		for (int p = 0; p < 2; p++) begin
			for (int s = 0; s < 32; s++) begin
				wr(p ? `CPGC_RX_OFF : `CPGC_TX_OFF, {3'h7, 5'(s)});
				if (p) exp_rx = exp_db(s[4], s[3:0]);
				else exp_tx = exp_db(s[4], s[3:0]);
				idle_look();
				chk_gains();
				rd(p ? `CPGC_RX_OFF : `CPGC_TX_OFF, d);
				chk("readback", d, {3'h0, 5'(s)});
			end
		end
	endtask

	// back-to-back writes to both registers
	task automatic t_b2b;
		@(posedge core_clk);
		wr(`CPGC_TX_OFF, 8'h0D);
		wr(`CPGC_RX_OFF, 8'h13);
		exp_tx = 5'h0C;
		exp_rx = 5'h1D;
		idle_look();
		chk_gains();
	endtask

	// unmapped write leaves gains alone, unmapped read answers zero
	task automatic t_unmapped;
		logic [7:0] d;
		@(posedge core_clk);
		wr(8'h28, 8'h1F);
		idle_look();
		chk_gains();
		rd(8'h28, d);
		chk("unmapped read", d, 8'h00);
	endtask

	// read on the edge after a write, then a read taken with a write
	task automatic t_wr_rd;
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= `CPGC_TX_OFF;
		reg_wdata <= 8'hE6;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk("answer valid", {7'h00, reg_rvalid}, 8'h01);
		chk("write then read", reg_rdata, 8'h06);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_rd    <= 1'b1;
		reg_wdata <= 8'h1F;
		#1;
		chk("answer one cycle", {7'h00, reg_rvalid}, 8'h00);
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
		chk("read with write", reg_rdata, 8'h06);
		exp_tx = 5'h11;
		idle_look();
		chk_gains();
	endtask

	// reset in mid-run clears registers and gains
	task automatic t_midrst;
		logic [7:0] d;
		wr(`CPGC_RX_OFF, 8'h15);
		idle_look();
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		exp_tx = 5'h00;
		exp_rx = 5'h00;
		@(posedge core_clk);
		#1;
		chk_gains();
		rd(`CPGC_RX_OFF, d);
		chk("rx after reset", d, 8'h00);
	endtask

	//------------------------------------------------------------
	// main sequence
	//------------------------------------------------------------
	initial begin
		core_clk  = 1'b0;
		rst_n     = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		exp_tx    = 5'h00;
		exp_rx    = 5'h00;
		n_fail    = 0;
		tests_run = 0;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_sweep();
		t_b2b();
		t_wr_rd();
		t_unmapped();
		t_midrst();
		give_verdict();
	end

endmodule

`default_nettype wire
